// >>> rtl/dpram_pkg.sv
// Shared constants for the dual-ported transfer buffer memory
package dpram_pkg;

  // ==========================================================================
  // Geometry
  localparam int unsigned DATA_W      = 16;
  localparam int unsigned BYTES_TOTAL = 2048;
  localparam int unsigned WORDS       = BYTES_TOTAL / 2;
  localparam int unsigned WADDR_W     = $clog2(WORDS);
  localparam int unsigned BADDR_W     = WADDR_W + 1;

  // ==========================================================================
  // Placement at the top of the Y data region (byte addresses)
  localparam int unsigned      EA_W        = 16;
  localparam logic [EA_W-1:0]  Y_SPACE_END = 16'h7FFF;
  localparam logic [EA_W-1:0]  BUF_BASE    = 16'h7800;

  // ==========================================================================
  // Reset value of read data
  localparam logic [DATA_W-1:0] RDATA_RST = 16'h0000;

endpackage : dpram_pkg

// >>> rtl/dpram_port_if.sv
// Interface carrying one access port between the top and the array
`timescale 1ns/1ps
`default_nettype none

interface dpram_port_if;
  import dpram_pkg::*;

  logic                en;
  logic                we_lo;
  logic                we_hi;
  logic [WADDR_W-1:0]  waddr;
  logic [DATA_W-1:0]   wdata;
  logic [DATA_W-1:0]   rdata;

  modport requester (
    output en,
    output we_lo,
    output we_hi,
    output waddr,
    output wdata,
    input  rdata
  );

  modport array (
    input  en,
    input  we_lo,
    input  we_hi,
    input  waddr,
    input  wdata,
    output rdata
  );

endinterface : dpram_port_if

`default_nettype wire

// >>> rtl/dpram_array.sv
// Two-port byte-lane word array with core write priority
`timescale 1ns/1ps
`default_nettype none

module dpram_array
  import dpram_pkg::*;
(
  // Clock and reset
  input  wire logic     mclk_i,
  input  wire logic     rstn_i,
  // Ports
  dpram_port_if.array   core_p,
  dpram_port_if.array   dma_p
);

  logic [DATA_W-1:0] mem [WORDS];
  logic [DATA_W-1:0] core_rd_reg;
  logic [DATA_W-1:0] dma_rd_reg;

  wire same_word = core_p.en && dma_p.en && (core_p.waddr == dma_p.waddr);
  // A DMA lane loses only where the core writes that same lane this cycle
  wire dma_lo_ok = dma_p.en && dma_p.we_lo && !(same_word && core_p.we_lo);
  wire dma_hi_ok = dma_p.en && dma_p.we_hi && !(same_word && core_p.we_hi);
  wire core_lo_ok = core_p.en && core_p.we_lo;
  wire core_hi_ok = core_p.en && core_p.we_hi;

  // ==========================================================================
  // Storage: no reset, as a real RAM macro would have none
  always_ff @(posedge mclk_i)
  begin
    if (dma_lo_ok) mem[dma_p.waddr][7:0]   <= dma_p.wdata[7:0];
    if (dma_hi_ok) mem[dma_p.waddr][15:8]  <= dma_p.wdata[15:8];
    if (core_lo_ok) mem[core_p.waddr][7:0]  <= core_p.wdata[7:0];
    if (core_hi_ok) mem[core_p.waddr][15:8] <= core_p.wdata[15:8];
  end

  // ==========================================================================
  // Read ports, independent of each other; old data on read-during-write
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      core_rd_reg <= RDATA_RST;
      dma_rd_reg  <= RDATA_RST;
    end
    else
    begin
      if (core_p.en) core_rd_reg <= mem[core_p.waddr];
      if (dma_p.en)  dma_rd_reg  <= mem[dma_p.waddr];
    end
  end

  assign core_p.rdata = core_rd_reg;
  assign dma_p.rdata  = dma_rd_reg;

endmodule : dpram_array

`default_nettype wire

// >>> rtl/dpram_top.sv
// Dual-ported transfer buffer memory for core and DMA controller
//
// Behaviour
// - 2 KB RAM, core port and DMA port
// - Sits at top of Y data region
// - Both ports accepted in same cycle
// - DMA never stalls or delays core
// - Same-location concurrent write: core data kept
// - Holds outbound and inbound peripheral transfer data
// - Separate low and high byte write enables
// - Byte read selects lane by address bit
`timescale 1ns/1ps
`default_nettype none

module dpram_top
(
  // Clock and reset
  input  wire logic                        mclk_i,
  input  wire logic                        rstn_i,
  // Core port: full data-space byte address
  input  wire logic                        core_en_i,
  input  wire logic                        core_we_i,
  input  wire logic                        core_byte_i,
  input  wire logic [dpram_pkg::EA_W-1:0]  core_addr_i,
  input  wire logic [dpram_pkg::DATA_W-1:0] core_wdata_i,
  output logic                             core_hit_o,
  output logic                             core_ready_o,
  output logic [dpram_pkg::DATA_W-1:0]     core_rdata_o,
  // DMA port: byte offset inside the buffer
  input  wire logic                        dma_en_i,
  input  wire logic                        dma_we_i,
  input  wire logic                        dma_byte_i,
  input  wire logic [dpram_pkg::BADDR_W-1:0] dma_addr_i,
  input  wire logic [dpram_pkg::DATA_W-1:0] dma_wdata_i,
  output logic                             dma_ready_o,
  output logic [dpram_pkg::DATA_W-1:0]     dma_rdata_o
);
  import dpram_pkg::*;

  dpram_port_if core_if ();
  dpram_port_if dma_if ();

  // ==========================================================================
  // Core side decode
  wire                core_sel   = core_en_i &&
                                   (core_addr_i >= BUF_BASE) &&
                                   (core_addr_i <= Y_SPACE_END);
  wire [BADDR_W-1:0]  core_boff  = BADDR_W'(core_addr_i - BUF_BASE);
  wire                core_lane  = core_boff[0];
  // Byte writes drive the low input byte onto the addressed lane
  wire [DATA_W-1:0]   core_wsh   = core_byte_i ? {core_wdata_i[7:0], core_wdata_i[7:0]}
                                               : core_wdata_i;
  wire                core_wlo   = core_we_i && (!core_byte_i || !core_lane);
  wire                core_whi   = core_we_i && (!core_byte_i ||  core_lane);

  assign core_if.en    = core_sel;
  assign core_if.we_lo = core_wlo;
  assign core_if.we_hi = core_whi;
  assign core_if.waddr = core_boff[BADDR_W-1:1];
  assign core_if.wdata = core_wsh;

  // ==========================================================================
  // DMA side decode; same lane handling, transfer data either direction
  wire                dma_lane   = dma_addr_i[0];
  wire [DATA_W-1:0]   dma_wsh    = dma_byte_i ? {dma_wdata_i[7:0], dma_wdata_i[7:0]}
                                              : dma_wdata_i;

  assign dma_if.en    = dma_en_i;
  assign dma_if.we_lo = dma_we_i && (!dma_byte_i || !dma_lane);
  assign dma_if.we_hi = dma_we_i && (!dma_byte_i ||  dma_lane);
  assign dma_if.waddr = dma_addr_i[BADDR_W-1:1];
  assign dma_if.wdata = dma_wsh;

  // ==========================================================================
  // Array holds 2 KB; both ports share no arbitration stall
  dpram_array u_array (
    .mclk_i (mclk_i),
    .rstn_i (rstn_i),
    .core_p (core_if.array),
    .dma_p  (dma_if.array)
  );

  // ==========================================================================
  // Lane select for reads, captured with the access
  logic core_lane_reg;
  logic core_byte_reg;
  logic core_hit_reg;
  logic dma_lane_reg;
  logic dma_byte_reg;

  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      core_lane_reg <= 1'b0;
      core_byte_reg <= 1'b0;
      core_hit_reg  <= 1'b0;
      dma_lane_reg  <= 1'b0;
      dma_byte_reg  <= 1'b0;
    end
    else
    begin
      core_hit_reg <= core_sel;
      if (core_sel)
      begin
        core_lane_reg <= core_lane;
        core_byte_reg <= core_byte_i;
      end
      if (dma_en_i)
      begin
        dma_lane_reg <= dma_lane;
        dma_byte_reg <= dma_byte_i;
      end
    end
  end

  // Byte reads place the chosen byte on the low lane, upper zero
  wire [DATA_W-1:0] core_rd_w = core_if.rdata;
  wire [DATA_W-1:0] dma_rd_w  = dma_if.rdata;
  wire [7:0]        core_rsel = core_lane_reg ? core_rd_w[15:8] : core_rd_w[7:0];
  wire [7:0]        dma_rsel  = dma_lane_reg  ? dma_rd_w[15:8]  : dma_rd_w[7:0];

  assign core_rdata_o = core_byte_reg ? {8'h00, core_rsel} : core_rd_w;
  assign dma_rdata_o  = dma_byte_reg  ? {8'h00, dma_rsel}  : dma_rd_w;
  assign core_hit_o   = core_hit_reg;
  // Neither port ever waits on the other
  assign core_ready_o = 1'b1;
  assign dma_ready_o  = 1'b1;

endmodule : dpram_top

`default_nettype wire

// >>> verification/dpram_top_checker.sv
// Port-level assertions for the dual-ported buffer memory
`timescale 1ns/1ps
`default_nettype none
module dpram_top_checker
  import dpram_pkg::*;
(
  // Watched ports
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic core_en_i,
  input wire logic core_we_i,
  input wire logic core_byte_i,
  input wire logic [EA_W-1:0] core_addr_i,
  input wire logic [DATA_W-1:0] core_wdata_i,
  input wire logic core_hit_o,
  input wire logic core_ready_o,
  input wire logic [DATA_W-1:0] core_rdata_o,
  input wire logic dma_en_i,
  input wire logic dma_we_i,
  input wire logic dma_byte_i,
  input wire logic [BADDR_W-1:0] dma_addr_i,
  input wire logic [DATA_W-1:0] dma_wdata_i,
  input wire logic dma_ready_o,
  input wire logic [DATA_W-1:0] dma_rdata_o
);
  wire logic hit_w = core_en_i && (core_addr_i >= BUF_BASE) && (core_addr_i <= Y_SPACE_END);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  a_core_no_wait: assert property (core_ready_o) else $error("core stalled");
  a_dma_no_wait: assert property (dma_ready_o) else $error("dma stalled");
  a_hit_flag: assert property (hit_w |=> core_hit_o) else $error("hit lost");
  a_miss_flag: assert property (!hit_w |=> !core_hit_o) else $error("false hit");
  a_core_hold: assert property (!hit_w |=> $stable(core_rdata_o)) else $error("core moved");
  a_dma_hold: assert property (!dma_en_i |=> $stable(dma_rdata_o)) else $error("dma moved");
  a_core_byte: assert property (hit_w && !core_we_i && core_byte_i
    |=> core_rdata_o[15:8] == 8'h00) else $error("core byte high");
  a_dma_byte: assert property (dma_en_i && !dma_we_i && dma_byte_i
    |=> dma_rdata_o[15:8] == 8'h00) else $error("dma byte high");
endmodule : dpram_top_checker
bind dpram_top dpram_top_checker dpram_top_checker_i (.*);
`default_nettype wire

// >>> verification/dma_agent.sv
// Behavioural DMA controller on the buffer's second port
`timescale 1ns/1ps
`default_nettype none
module dma_agent
  import dpram_pkg::*;
(
  // Request to the buffer
  output logic en_o,
  output logic we_o,
  output logic byte_o,
  output logic [BADDR_W-1:0] addr_o,
  output logic [DATA_W-1:0] wdata_o
);
  initial {en_o, we_o, byte_o, addr_o, wdata_o} = '0;
  // Called at an edge, so the request stands one whole cycle
  task automatic drive(input logic e, w, b, input logic [10:0] a, input logic [15:0] d);
    en_o <= e;
    we_o <= w;
    byte_o <= b;
    addr_o <= a;
    wdata_o <= e ? d : ~wdata_o;
  endtask : drive
endmodule : dma_agent
`default_nettype wire

// >>> verification/dpram_top_test.sv
// Self-checking testbench for the dual-ported buffer memory
`timescale 1ns/1ps
`default_nettype none
module dpram_top_test;
  import dpram_pkg::*;
  logic mclk_i = 0, rstn_i = 0, core_en_i = 0, core_we_i = 0, core_byte_i = 0;
  logic [15:0] core_addr_i = '0, core_wdata_i = '0, core_rdata_o, dma_rdata_o, dma_wdata_i;
  logic core_hit_o, core_ready_o, dma_ready_o, dma_en_i, dma_we_i, dma_byte_i;
  logic [10:0] dma_addr_i;
  int error_cnt = 0, num_checks = 0;
  dma_agent dma_agent_i (.en_o(dma_en_i), .we_o(dma_we_i), .byte_o(dma_byte_i),
    .addr_o(dma_addr_i), .wdata_o(dma_wdata_i));
  dpram_top dpram_top_i (.*);
  initial forever #50 mclk_i = ~mclk_i;
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    num_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // Both ports change together just after an edge
  task automatic cyc(input logic ce, cw, cb, input logic [15:0] ca, cd,
                     input logic de, dw, db, input logic [10:0] da, input logic [15:0] dd);
    @(posedge mclk_i);
    core_en_i <= ce;
    core_we_i <= cw;
    core_byte_i <= cb;
    core_addr_i <= ca;
    core_wdata_i <= cd;
    dma_agent_i.drive(de, dw, db, da, dd);
  endtask : cyc
  task automatic idle();
    cyc(0, 0, 0, 16'h0000, 16'h0000, 0, 0, 0, 11'h000, 16'h0000);
    #1;
  endtask : idle
  task automatic t_xfer();
    cyc(1, 1, 0, 16'h7FFE, 16'hA5C3, 1, 1, 0, 11'h002, 16'h1234);
    cyc(1, 0, 0, 16'h7802, 16'h0000, 1, 0, 0, 11'h7FE, 16'h0000);
    idle();
    chk("dma_rd", dma_rdata_o, 16'hA5C3);
    chk("core_rd", core_rdata_o, 16'h1234);
    chk("hit", {15'h0000, core_hit_o}, 16'h0001);
  endtask : t_xfer
  task automatic t_conc();
    cyc(1, 1, 0, 16'h7804, 16'hC0DE, 1, 1, 0, 11'h004, 16'hDEAD);
    cyc(1, 0, 0, 16'h7804, 16'h0000, 1, 0, 0, 11'h004, 16'h0000);
    idle();
    chk("clash_core", core_rdata_o, 16'hC0DE);
    chk("clash_dma", dma_rdata_o, 16'hC0DE);
    chk("core_ready", {15'h0000, core_ready_o}, 16'h0001);
    chk("dma_ready", {15'h0000, dma_ready_o}, 16'h0001);
    // Core byte on the low lane against a DMA word: DMA keeps only the high lane
    cyc(1, 1, 1, 16'h7804, 16'h0011, 1, 1, 0, 11'h004, 16'h2233);
    cyc(1, 0, 0, 16'h7804, 16'h0000, 1, 0, 0, 11'h004, 16'h0000);
    idle();
    chk("lane_core", core_rdata_o, 16'h2211);
    chk("lane_dma", dma_rdata_o, 16'h2211);
  endtask : t_conc
  task automatic t_byte();
    cyc(1, 1, 0, 16'h7806, 16'h0000, 0, 0, 0, 11'h000, 16'h0000);
    cyc(1, 1, 1, 16'h7807, 16'h0055, 1, 1, 1, 11'h006, 16'h0066);
    cyc(1, 0, 0, 16'h7806, 16'h0000, 1, 0, 1, 11'h007, 16'h0000);
    idle();
    chk("lanes", core_rdata_o, 16'h5566);
    chk("byte_rd", dma_rdata_o, 16'h0055);
    cyc(1, 0, 1, 16'h7807, 16'h0000, 1, 0, 1, 11'h006, 16'h0000);
    idle();
    chk("core_byte_rd", core_rdata_o, 16'h0055);
    chk("dma_byte_lo", dma_rdata_o, 16'h0066);
  endtask : t_byte
  task automatic t_miss();
    cyc(1, 1, 0, 16'h77FE, 16'hFFFF, 0, 0, 0, 11'h000, 16'h0000);
    idle();
    chk("miss", {15'h0000, core_hit_o}, 16'h0000);
    chk("miss_rd", core_rdata_o, 16'h0055);
    // Above the top of Y data space: refused as well
    cyc(1, 1, 0, 16'h8000, 16'hFFFF, 0, 0, 0, 11'h000, 16'h0000);
    idle();
    chk("psv_miss", {15'h0000, core_hit_o}, 16'h0000);
    cyc(1, 0, 0, 16'h7FFE, 16'h0000, 0, 0, 0, 11'h000, 16'h0000);
    idle();
    chk("no_alias", core_rdata_o, 16'hA5C3);
  endtask : t_miss
  // Mid-run reset clears the read data and hit outputs but not the stored words
  task automatic t_reset();
    @(posedge mclk_i);
    rstn_i <= 1'b0;
    #1;
    chk("rst_core", core_rdata_o, RDATA_RST);
    chk("rst_dma", dma_rdata_o, RDATA_RST);
    chk("rst_hit", {15'h0000, core_hit_o}, 16'h0000);
    repeat (3) @(posedge mclk_i);
    rstn_i <= 1'b1;
    cyc(1, 0, 0, 16'h7FFE, 16'h0000, 1, 0, 0, 11'h002, 16'h0000);
    idle();
    chk("keep_core", core_rdata_o, 16'hA5C3);
    chk("keep_dma", dma_rdata_o, 16'h1234);
  endtask : t_reset
  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  initial
  begin
    repeat (3) @(posedge mclk_i);
    rstn_i <= 1'b1;
    t_xfer();
    t_conc();
    t_byte();
    t_miss();
    t_reset();
    print_verdict();
  end
  // The run needs about 30 cycles
  initial
  begin
    repeat (200) @(posedge mclk_i);
    error_cnt++;
    print_verdict();
  end
endmodule : dpram_top_test
`default_nettype wire
